/* hdl/itd_pkg.sv */
// constants, register map and function codes of the input terminal decoder
package itd_pkg;
	// apb register byte offsets
	localparam logic [7:0] SEL_ONE_OFS   = 8'h00;
	localparam logic [7:0] SEL_TWO_OFS   = 8'h04;
	localparam logic [7:0] SEL_THREE_OFS = 8'h08;
	localparam logic [7:0] SEL_FOUR_OFS  = 8'h0C;
	localparam logic [7:0] SEL_FIVE_OFS  = 8'h10;
	localparam logic [7:0] SEL_SIX_OFS   = 8'h14;
	localparam logic [7:0] SEL_FAST_OFS  = 8'h18;
	localparam logic [7:0] SEL_SPARE_OFS = 8'h1C;
	localparam logic [7:0] CONFIG_OFS    = 8'h20;
	localparam logic [7:0] CONTROL_OFS   = 8'h24;
	localparam logic [7:0] STATUS_OFS    = 8'h28;
	localparam logic [7:0] LEVELS_OFS    = 8'h2C;
	localparam int SEL_COUNT = 8;
	localparam int TERM_COUNT = 7;
	localparam int CODE_W = 7;
	localparam logic [CODE_W-1:0] CODE_MAX = 7'h41;
	// default function codes
	localparam logic [CODE_W-1:0] DEF_ONE = 7'h01;
	localparam logic [CODE_W-1:0] DEF_TWO = 7'h02;
	localparam logic [CODE_W-1:0] DEF_THREE = 7'h04;
	localparam logic [CODE_W-1:0] DEF_FOUR = 7'h07;
	localparam logic [CODE_W-1:0] DEF_FIVE = 7'h08;
	localparam logic [CODE_W-1:0] DEF_SIX = 7'h00;
	localparam logic [CODE_W-1:0] DEF_FAST = 7'h2D;
	localparam logic [CODE_W-1:0] DEF_SPARE = 7'h00;
	localparam logic [CODE_W-1:0] ALT_ONE = 7'h3A;
	localparam logic [CODE_W-1:0] ALT_TWO = 7'h3B;
	localparam logic [CODE_W-1:0] ALT_THREE = 7'h3C;
	localparam logic [CODE_W-1:0] ALT_FOUR = 7'h3D;
	localparam logic [CODE_W-1:0] ALT_FIVE = 7'h3E;
	localparam logic [CODE_W-1:0] ALT_SIX = 7'h3F;
	// function codes
	localparam logic [CODE_W-1:0] FN_FWD = 7'h01;
	localparam logic [CODE_W-1:0] FN_REV = 7'h02;
	localparam logic [CODE_W-1:0] FN_THREE_WIRE = 7'h03;
	localparam logic [CODE_W-1:0] FN_JOG_FWD = 7'h04;
	localparam logic [CODE_W-1:0] FN_JOG_REV = 7'h05;
	localparam logic [CODE_W-1:0] FN_COAST = 7'h06;
	localparam logic [CODE_W-1:0] FN_RESET = 7'h07;
	localparam logic [CODE_W-1:0] FN_EXT_NO = 7'h08;
	localparam logic [CODE_W-1:0] FN_EXT_NC = 7'h09;
	localparam logic [CODE_W-1:0] FN_ESTOP = 7'h0A;
	localparam logic [CODE_W-1:0] FN_UP = 7'h0C;
	localparam logic [CODE_W-1:0] FN_DOWN = 7'h0D;
	localparam logic [CODE_W-1:0] FN_UPDN_CLR = 7'h0E;
	// config, control and status fields
	localparam logic [1:0] RUN_CH_TERMINAL = 2'h1;
	localparam logic [1:0] CTRL_MODE_ALT_A = 2'h2;
	localparam logic [1:0] CTRL_MODE_ALT_B = 2'h3;
	localparam int CFG_CTRL_MODE_LSB = 0;
	localparam int CFG_RUN_CH_LSB = 2;
	localparam int CFG_UPDN_SRC_BIT = 4;
	localparam int CFG_AUX_BIT = 5;
	localparam int CTL_LOAD_DEF_BIT = 0;
	localparam int STS_EXT_FAULT_BIT = 0;
	localparam logic [7:0] EXT_FAULT_CODE = 8'h13;
	localparam logic [31:0] CONFIG_RST = 32'h00000000;
	// debounce
	localparam int DEBOUNCE_US = 2000;
	localparam int CLK_MHZ = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
	localparam int DB_CNT_W = 15;
endpackage : itd_pkg

/* hdl/itd_debounce.sv */
// synchroniser and debouncer for one active-low terminal
`timescale 1ns/1ps
module itd_debounce
	import itd_pkg::*;
#(
	parameter int STABLE_CYC = DEBOUNCE_CYC
) (
	input  wire logic clk_sys,     // control clock
	input  wire logic rstn,        // sync reset, active low
	input  wire logic pinN,        // raw terminal, low when shorted to common
	output logic      active       // debounced active level
);
	logic                syncA_reg;
	logic                syncB_reg;
	logic [DB_CNT_W-1:0] cnt_reg;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			syncA_reg <= 1'b1;
			syncB_reg <= 1'b1;
		end else begin
			syncA_reg <= pinN;
			syncB_reg <= syncA_reg;
		end
	end

	// output follows only after a steady level for the whole window
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt_reg <= '0;
			active  <= 1'b0;
		end else if ((!syncB_reg) == active) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= DB_CNT_W'(STABLE_CYC - 1)) begin
			cnt_reg <= '0;
			active  <= !syncB_reg;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : itd_debounce

/* hdl/itd_decoder.sv */
// input terminal function decoder with apb register file
`timescale 1ns/1ps
module itd_decoder
	import itd_pkg::*;
#(
	parameter int STABLE_CYC = DEBOUNCE_CYC
) (
	input  wire logic        clk_sys,        // control clock 10 MHz
	input  wire logic        rstn,           // sync reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb access phase
	input  wire logic        pwrite,         // apb direction
	input  wire logic [7:0]  paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error
	input  wire logic [5:0]  terminalN,      // six terminals, low when shorted
	input  wire logic        fastTerminalN,  // fast pulse terminal as level
	output logic             forwardRunCmd,  // forward run
	output logic             reverseRunCmd,  // reverse run
	output logic             threeWireCtl,   // three-wire control input
	output logic             jogFwd,         // forward jog
	output logic             jogRev,         // reverse jog
	output logic             coastStop,      // coast stop request
	output logic             faultReset,     // fault reset request
	output logic             extFault,       // external equipment fault
	output logic [7:0]       extFaultCode,   // fault code while extFault
	output logic             emergencyStop,  // emergency stop request
	output logic             freqUp,         // frequency increment
	output logic             freqDown,       // frequency decrement
	output logic             updnClear       // clear up/down adjustment
);
	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} itd_apb_t;

	logic [CODE_W-1:0] sel_reg [SEL_COUNT];
	logic [CODE_W-1:0] def_next [SEL_COUNT];
	logic [31:0]       config_reg;
	logic              extFaultSticky_reg;
	logic [TERM_COUNT-1:0] termActive;
	logic [TERM_COUNT-1:0] termActive_reg;
	itd_apb_t          state_reg;
	logic              wrStrobe;
	logic [1:0]        ctrlMode;
	logic [1:0]        runCh;
	logic              updnSrc;
	logic              auxNonzero;
	logic              altMode;
	logic              runByTerminal;
	logic [2:0]        selIdx;
	logic              selHit;

	assign ctrlMode      = config_reg[CFG_CTRL_MODE_LSB +: 2];
	assign runCh         = config_reg[CFG_RUN_CH_LSB +: 2];
	assign updnSrc       = config_reg[CFG_UPDN_SRC_BIT];
	assign auxNonzero    = config_reg[CFG_AUX_BIT];
	assign altMode       = (ctrlMode == CTRL_MODE_ALT_A) || (ctrlMode == CTRL_MODE_ALT_B);
	assign runByTerminal = (runCh == RUN_CH_TERMINAL);

	// terminal conditioning
	genvar g;
	generate
		for (g = 0; g < TERM_COUNT; g++) begin : g_db
			itd_debounce #(.STABLE_CYC(STABLE_CYC)) u_db (
				.clk_sys (clk_sys),
				.rstn    (rstn),
				.pinN    ((g < 6) ? terminalN[g % 6] : fastTerminalN),
				.active  (termActive[g])
			);
		end
	endgenerate

	// defaults depend on live configuration
	always_comb begin
		def_next[0] = altMode ? ALT_ONE : DEF_ONE;
		def_next[1] = auxNonzero ? ALT_TWO : DEF_TWO;
		def_next[2] = altMode ? ALT_THREE : DEF_THREE;
		def_next[3] = altMode ? ALT_FOUR : DEF_FOUR;
		def_next[4] = altMode ? ALT_FIVE : DEF_FIVE;
		def_next[5] = altMode ? ALT_SIX : DEF_SIX;
		def_next[6] = DEF_FAST;
		def_next[7] = DEF_SPARE;
	end

	// apb: one wait-free access phase
	assign pready   = (state_reg == ST_ACCESS);
	assign selIdx   = paddr[4:2];
	assign selHit   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	assign wrStrobe = psel && penable && pwrite && pready;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE:   state_reg <= (psel && !penable) ? ST_ACCESS : ST_IDLE;
				ST_ACCESS: state_reg <= ST_IDLE;
				default:   state_reg <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		pslverr = 1'b0;
		if (pready && psel) begin
			if (!(selHit || paddr == CONFIG_OFS || paddr == CONTROL_OFS ||
			      paddr == STATUS_OFS || paddr == LEVELS_OFS)) begin
				pslverr = 1'b1;
			end else if (pwrite && selHit && pwdata > {25'h0, CODE_MAX}) begin
				pslverr = 1'b1;
			end
		end
	end

	// selectors: reset loads plain defaults, load-default follows live config
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sel_reg[0] <= DEF_ONE;
			sel_reg[1] <= DEF_TWO;
			sel_reg[2] <= DEF_THREE;
			sel_reg[3] <= DEF_FOUR;
			sel_reg[4] <= DEF_FIVE;
			sel_reg[5] <= DEF_SIX;
			sel_reg[6] <= DEF_FAST;
			sel_reg[7] <= DEF_SPARE;
		end else if (wrStrobe && paddr == CONTROL_OFS && pwdata[CTL_LOAD_DEF_BIT]) begin
			for (int i = 0; i < SEL_COUNT; i++) begin
				sel_reg[i] <= def_next[i];
			end
		end else if (wrStrobe && selHit && !pslverr && selIdx != 3'h7) begin
			sel_reg[selIdx] <= pwdata[CODE_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			config_reg <= CONFIG_RST;
		end else if (wrStrobe && paddr == CONFIG_OFS) begin
			config_reg <= {26'h0, pwdata[5:0]};
		end
	end

	// decode: any terminal with a matching code asserts the function; run and jog also need runByTerminal, up and down need updnSrc
	function automatic logic anyHit(input logic [CODE_W-1:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < TERM_COUNT; i++) begin
			hit = hit | (termActive[i] && sel_reg[i] == code);
		end
		return hit;
	endfunction : anyHit

	// nc contact: a configured terminal that is open signals the fault
	function automatic logic ncOpen();
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < TERM_COUNT; i++) begin
			hit = hit | (!termActive[i] && sel_reg[i] == FN_EXT_NC);
		end
		return hit;
	endfunction : ncOpen

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			forwardRunCmd <= 1'b0;
			reverseRunCmd <= 1'b0;
			jogFwd        <= 1'b0;
			jogRev        <= 1'b0;
		end else begin
			forwardRunCmd <= runByTerminal && anyHit(FN_FWD);
			reverseRunCmd <= runByTerminal && anyHit(FN_REV);
			jogFwd        <= runByTerminal && anyHit(FN_JOG_FWD);
			jogRev        <= runByTerminal && anyHit(FN_JOG_REV);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			threeWireCtl  <= 1'b0;
			coastStop     <= 1'b0;
			faultReset    <= 1'b0;
			emergencyStop <= 1'b0;
		end else begin
			threeWireCtl  <= anyHit(FN_THREE_WIRE);
			coastStop     <= anyHit(FN_COAST);
			faultReset    <= anyHit(FN_RESET);
			emergencyStop <= anyHit(FN_ESTOP);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			freqUp    <= 1'b0;
			freqDown  <= 1'b0;
			updnClear <= 1'b0;
		end else begin
			freqUp    <= updnSrc && anyHit(FN_UP);
			freqDown  <= updnSrc && anyHit(FN_DOWN);
			updnClear <= anyHit(FN_UPDN_CLR);
		end
	end

	// external fault latches until a reset request; a new fault wins
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			extFaultSticky_reg <= 1'b0;
			extFault           <= 1'b0;
			extFaultCode       <= 8'h00;
		end else begin
			if (anyHit(FN_EXT_NO) || ncOpen()) begin
				extFaultSticky_reg <= 1'b1;
			end else if (faultReset) begin
				extFaultSticky_reg <= 1'b0;
			end
			extFault     <= extFaultSticky_reg;
			extFaultCode <= extFaultSticky_reg ? EXT_FAULT_CODE : 8'h00;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			termActive_reg <= '0;
		end else begin
			termActive_reg <= termActive;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0) begin
				prdata <= {25'h0, sel_reg[paddr[4:2]]};
			end else if (paddr == CONFIG_OFS) begin
				prdata <= config_reg;
			end else if (paddr == STATUS_OFS) begin
				prdata <= {23'h0, extFaultSticky_reg, extFaultCode};
			end else if (paddr == LEVELS_OFS) begin
				prdata <= {25'h0, termActive_reg};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end
endmodule : itd_decoder

/* testbench/itd_decoder_properties.sv */
// port assertions of the input terminal decoder
`timescale 1ns/1ps
module itd_decoder_properties
	import itd_pkg::*;
#(
	parameter int STABLE_CYC = DEBOUNCE_CYC
) (
	input wire logic        clk_sys,       // clock
	input wire logic        rstn,          // reset
	input wire logic        psel,          // apb
	input wire logic        penable,       // apb
	input wire logic        pwrite,        // apb
	input wire logic [7:0]  paddr,         // apb
	input wire logic [31:0] pwdata,        // apb
	input wire logic [31:0] prdata,        // apb
	input wire logic        pready,        // apb
	input wire logic        pslverr,       // apb
	input wire logic [5:0]  terminalN,     // terminals
	input wire logic        fastTerminalN, // fast terminal
	input wire logic        forwardRunCmd, // command
	input wire logic        coastStop,     // command
	input wire logic        faultReset,    // command
	input wire logic        emergencyStop, // command
	input wire logic        extFault,      // fault
	input wire logic [7:0]  extFaultCode   // fault code
);
	logic allOpen;
	logic anyCmd;
	assign allOpen = &terminalN & fastTerminalN;
	assign anyCmd = forwardRunCmd | coastStop | faultReset | emergencyStop;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_CODE_RANGE: assert property (psel && penable && pwrite && paddr <= SEL_FAST_OFS
		&& paddr[1:0] == 2'h0 && pwdata > 32'h00000041 |-> pslverr)
		else $error("selector code above range accepted");
	AST_READ_HOLD: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved without read");
	AST_FAULT_CODE: assert property (extFaultCode == (extFault ? 8'h13 : 8'h00))
		else $error("fault code wrong");
	AST_FAULT_STICKY: assert property ($fell(extFault) |-> faultReset || $past(faultReset))
		else $error("fault cleared without reset");
	AST_CMD_NEEDS_CONTACT: assert property ($rose(anyCmd) |-> !$past(allOpen, 4))
		else $error("command without closed contact");
endmodule : itd_decoder_properties
bind itd_decoder itd_decoder_properties #(.STABLE_CYC(STABLE_CYC)) u_itd_decoder_properties (.*);

/* testbench/itd_contacts.sv */
// contact bank on the terminals, chattering three cycles on every change
`timescale 1ns/1ps
module itd_contacts (
	input  wire logic       clk_sys,       // clock
	input  wire logic [6:0] closeReq,      // 1 closes contact, bit 6 fast terminal
	output logic      [5:0] terminalN,     // six terminals
	output logic            fastTerminalN  // fast terminal
);
	logic [6:0] lineN = 7'h7F; // open contact pulled up
	logic [6:0] lastReq = 7'h00;
	logic [6:0] chg = 7'h00;
	logic [1:0] bounce = 2'h0;
	// odd toggle count so the line settles on the new level
	always @(posedge clk_sys) begin
		if (bounce != 2'h0) begin
			lineN <= lineN ^ chg;
			bounce <= bounce - 2'h1;
		end else if (closeReq !== lastReq) begin
			chg <= closeReq ^ lastReq;
			lastReq <= closeReq;
			bounce <= 2'h3;
		end
	end
	assign terminalN = lineN[5:0];
	assign fastTerminalN = lineN[6];
endmodule : itd_contacts

/* testbench/itd_decoder_tb_top.sv */
// self-checking bench of the input terminal decoder
`timescale 1ns/1ps
module itd_decoder_tb_top
	import itd_pkg::*;
;
	localparam int SETTLE = 16;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  terminalN;
	logic        fastTerminalN;
	logic [6:0]  closeReq = 7'h00;
	logic [10:0] cmdV;
	logic        extFault;
	logic [7:0]  extFaultCode;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cycles = 0;
	always #50 clk_sys = ~clk_sys;
	itd_decoder #(.STABLE_CYC(4)) u_itd_decoder (
		.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.terminalN(terminalN), .fastTerminalN(fastTerminalN), .forwardRunCmd(cmdV[0]),
		.reverseRunCmd(cmdV[1]), .threeWireCtl(cmdV[2]), .jogFwd(cmdV[3]), .jogRev(cmdV[4]),
		.coastStop(cmdV[5]), .faultReset(cmdV[6]), .emergencyStop(cmdV[7]), .freqUp(cmdV[8]),
		.freqDown(cmdV[9]), .updnClear(cmdV[10]), .extFault(extFault),
		.extFaultCode(extFaultCode));
	itd_contacts u_itd_contacts (.clk_sys(clk_sys), .closeReq(closeReq),
		.terminalN(terminalN), .fastTerminalN(fastTerminalN));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk("register", exp, rd);
	endtask : rdc
	task automatic press(input logic [6:0] mask, input logic [10:0] exp);
		closeReq <= mask;
		repeat (SETTLE) @(posedge clk_sys);
		chk("commands", {21'h0, exp}, {21'h0, cmdV});
	endtask : press
	task automatic t_defaults();
		logic [6:0] exp [8] = '{7'h01, 7'h02, 7'h04, 7'h07, 7'h08, 7'h00, 7'h2D, 7'h00};
		apb(1'b1, SEL_SPARE_OFS, 32'h00000005);
		for (int i = 0; i < 8; i++) begin
			rdc(8'(i * 4), {25'h0, exp[i]});
		end
	endtask : t_defaults
	task automatic t_alt();
		apb(1'b1, CONFIG_OFS, 32'h00000023);
		apb(1'b1, CONTROL_OFS, 32'h00000001);
		for (int i = 0; i < 6; i++) begin
			rdc(8'(i * 4), 32'(i) + 32'h0000003A);
		end
		apb(1'b1, CONFIG_OFS, 32'h00000020);
		apb(1'b1, CONTROL_OFS, 32'h00000001);
		rdc(SEL_ONE_OFS, 32'h00000001);
		rdc(SEL_TWO_OFS, 32'h0000003B);
		apb(1'b1, CONFIG_OFS, 32'h00000002);
		apb(1'b1, CONTROL_OFS, 32'h00000001);
		rdc(SEL_ONE_OFS, 32'h0000003A);
		rdc(SEL_TWO_OFS, 32'h00000002);
		rdc(SEL_SIX_OFS, 32'h0000003F);
		rdc(CONFIG_OFS, 32'h00000002);
		apb(1'b1, CONFIG_OFS, 32'h00000000);
		apb(1'b1, CONTROL_OFS, 32'h00000001);
	endtask : t_alt
	task automatic t_refuse();
		apb(1'b1, SEL_ONE_OFS, 32'h00000042);
		chk("error", 32'h1, {31'h0, err});
		rdc(SEL_ONE_OFS, 32'h00000001);
		apb(1'b1, SEL_ONE_OFS, 32'h00000080);
		chk("error", 32'h1, {31'h0, err});
		rdc(SEL_ONE_OFS, 32'h00000001);
		apb(1'b1, SEL_ONE_OFS, 32'h00000041);
		chk("error", 32'h0, {31'h0, err});
		rdc(SEL_ONE_OFS, 32'h00000041);
		apb(1'b0, 8'h30, 32'h00000000);
		chk("error", 32'h1, {31'h0, err});
		apb(1'b1, SEL_ONE_OFS, 32'h00000001);
	endtask : t_refuse
	task automatic t_funcs();
		logic [6:0] code [12] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h0A,
			7'h0C, 7'h0D, 7'h0E, 7'h0B};
		apb(1'b1, CONFIG_OFS, 32'h00000014);
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, SEL_THREE_OFS, {25'h0, code[i]});
			press(7'h04, (i < 11) ? 11'(1 << i) : 11'h000);
			press(7'h00, 11'h000);
		end
	endtask : t_funcs
	task automatic t_gate();
		logic [6:0]  code [3] = '{7'h01, 7'h0C, 7'h07};
		logic [10:0] exp [3] = '{11'h000, 11'h000, 11'h040};
		apb(1'b1, CONFIG_OFS, 32'h00000000);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, SEL_THREE_OFS, {25'h0, code[i]});
			press(7'h04, exp[i]);
			press(7'h00, 11'h000);
		end
	endtask : t_gate
	task automatic t_or();
		apb(1'b1, CONFIG_OFS, 32'h00000004);
		apb(1'b1, SEL_THREE_OFS, 32'h00000006);
		apb(1'b1, SEL_FAST_OFS, 32'h00000006);
		press(7'h40, 11'h020);
		press(7'h44, 11'h020);
		rdc(LEVELS_OFS, 32'h00000044);
		press(7'h04, 11'h020);
		press(7'h00, 11'h000);
	endtask : t_or
	task automatic t_fault();
		press(7'h10, 11'h000);
		chk("fault", 32'h1, {31'h0, extFault});
		chk("fault code", 32'h13, {24'h0, extFaultCode});
		rdc(STATUS_OFS, 32'h00000113);
		press(7'h00, 11'h000);
		chk("fault", 32'h1, {31'h0, extFault});
		press(7'h08, 11'h040);
		chk("fault", 32'h0, {31'h0, extFault});
		apb(1'b1, SEL_SIX_OFS, 32'h00000009);
		press(7'h00, 11'h000);
		chk("fault", 32'h1, {31'h0, extFault});
		press(7'h28, 11'h040);
		chk("fault", 32'h0, {31'h0, extFault});
		apb(1'b1, SEL_SIX_OFS, 32'h00000000);
	endtask : t_fault
	// mid-run reset must drop a latched fault and restore plain defaults
	task automatic t_reset();
		press(7'h00, 11'h000);
		apb(1'b1, SEL_SIX_OFS, 32'h00000009);
		apb(1'b1, SEL_ONE_OFS, 32'h00000010);
		chk("fault", 32'h1, {31'h0, extFault});
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk("fault", 32'h0, {31'h0, extFault});
		rdc(SEL_ONE_OFS, 32'h00000001);
		rdc(SEL_SIX_OFS, 32'h00000000);
		rdc(CONFIG_OFS, 32'h00000000);
	endtask : t_reset
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	// run is far shorter than this, so reaching it means a hang
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_defaults();
		t_alt();
		t_refuse();
		t_funcs();
		t_gate();
		t_or();
		t_fault();
		t_reset();
		final_report();
	end
endmodule : itd_decoder_tb_top
